// [inc/swt_pkg.sv]
// Purpose: Shared constants and types for the switch table indirect access block
// Assumes: 16-bit register words, 72-bit indirect data holding register
// Notes:   Table select sits in control bits 11:10
package swt_pkg;
   // ==========================================
   // Register offsets
   localparam logic [15:0] CTRL_OFS = 16'h04a0;
   localparam logic [15:0] D71_OFS  = 16'h04a2;
   localparam logic [15:0] DUP_OFS  = 16'h04a4;
   localparam logic [15:0] D47_OFS  = 16'h04a6;
   localparam logic [15:0] D15_OFS  = 16'h04a8;
   localparam logic [15:0] D31_OFS  = 16'h04aa;
   // ==========================================
   // Control word fields
   localparam int          CTL_RD_BIT  = 12;
   localparam int          CTL_TBL_LSB = 10;
   localparam logic [1:0]  TBL_STATIC  = 2'h0;
   localparam logic [1:0]  TBL_VLAN    = 2'h1;
   localparam logic [1:0]  TBL_DYN     = 2'h2;
   localparam logic [1:0]  TBL_MIB     = 2'h3;
   localparam logic [15:0] CTRL_RST    = 16'h0000;
   // ==========================================
   // Counter layout
   localparam int          MIB_PER_PORT = 32;
   localparam int          MIB_ENTRIES  = 64;
   localparam logic [9:0]  MIB_LIMIT    = 10'h040;
   localparam int          MIB_OVF_BIT  = 31;
   localparam int          MIB_VLD_BIT  = 30;
   localparam int          DROP_NUM     = 4;
   localparam logic [9:0]  DROP_P1_TX   = 10'h100;
   localparam logic [9:0]  DROP_P2_TX   = 10'h101;
   localparam logic [9:0]  DROP_P1_RX   = 10'h103;
   localparam logic [9:0]  DROP_P2_RX   = 10'h104;
   localparam logic [15:0] DROP_RST     = 16'h0000;
   // ==========================================
   // Static entry layout
   localparam int          ST_ENTRIES   = 8;
   localparam int          ST_W         = 58;
   localparam int          ST_FID_LSB   = 54;
   localparam int          ST_USEFID    = 53;
   localparam int          ST_OVR       = 52;
   localparam int          ST_VALID     = 51;
   localparam int          ST_PORTS_LSB = 48;
   localparam logic [2:0]  PORTS_BCAST  = 3'h7;
   localparam logic [57:0] ST_RST       = 58'h0;
   // ==========================================
   // Dynamic entry layout
   localparam int          DATA_W        = 72;
   localparam int          DYN_NRDY      = 71;
   localparam int          DYN_EMPTY     = 66;
   localparam int          DYN_CNT_LSB   = 56;
   localparam int          DYN_STAMP_LSB = 54;
   localparam int          DYN_PORT_LSB  = 52;
   localparam int          DYN_FID_LSB   = 48;
   localparam int          DYN_DEPTH     = 1024;
   // ==========================================
   // Access sequencer
   typedef enum logic [1:0] {S_IDLE, S_FETCH, S_LOAD} acc_state_t;
endpackage

// [inc/lookup_if.sv]
// Purpose: Lookup and table read signals between the core and its two tables
// Assumes: Single clock domain
// Notes:   Lookup results are combinational within the cycle
`timescale 1ns/1ps
interface lookup_if;
   logic [47:0] mac;
   logic [3:0]  filter_group_id;
   logic        req;
   logic [1:0]  learn_port;
   logic [1:0]  stamp;
   logic        dyn_hit;
   logic [1:0]  dyn_port;
   logic        st_hit;
   logic [2:0]  st_ports;
   logic        st_ovr;
   logic        rd_en;
   logic [9:0]  rd_idx;
   logic [71:0] rd_data;
   modport core (output mac, filter_group_id, req, learn_port, stamp, rd_en, rd_idx,
                 input dyn_hit, dyn_port, st_hit, st_ports, st_ovr, rd_data);
   modport stat (input mac, filter_group_id, output st_hit, st_ports, st_ovr);
   modport dyn  (input mac, filter_group_id, req, learn_port, stamp, rd_en, rd_idx,
                 output dyn_hit, dyn_port, rd_data);
endinterface

// [core/static_match.sv]
// Purpose: Parallel match of a lookup against all static entries
// Assumes: Table contents held by the core
// Notes:   Lowest matching entry wins
`timescale 1ns/1ps
module static_match #(
   parameter int ENTRIES = swt_pkg::ST_ENTRIES
) (
   input  wire logic [ENTRIES-1:0][swt_pkg::ST_W-1:0] i_table,
   lookup_if.stat                                      lkp
);
   logic [ENTRIES-1:0] hit;

   genvar g;
   generate
      for (g = 0; g < ENTRIES; g++) begin : g_ent
         // Invalid entries never match group id joins the key on request
         assign hit[g] = i_table[g][swt_pkg::ST_VALID] && (i_table[g][47:0] == lkp.mac) &&
                         (!i_table[g][swt_pkg::ST_USEFID] ||
                          (i_table[g][swt_pkg::ST_FID_LSB +: 4] == lkp.filter_group_id));
      end
   endgenerate

   always_comb begin
      lkp.st_hit   = 1'b0;
      lkp.st_ports = 3'h0;
      lkp.st_ovr   = 1'b0;
      for (int i = ENTRIES - 1; i >= 0; i--) begin
         if (hit[i]) begin
            lkp.st_hit   = 1'b1;
            lkp.st_ports = i_table[i][swt_pkg::ST_PORTS_LSB +: 3];
            lkp.st_ovr   = i_table[i][swt_pkg::ST_OVR];
         end
      end
   end
endmodule

// [core/dyn_table.sv]
// Purpose: Learned address table, direct mapped by a hash of address and group
// Assumes: Learning requests come from source lookups only
// Notes:   A colliding new address evicts the old one; count is unchanged then
`timescale 1ns/1ps
module dyn_table #(
   parameter int DEPTH = swt_pkg::DYN_DEPTH,
   parameter int AW    = 10
) (
   input  wire logic i_clk_sys,
   input  wire logic i_rst,
   lookup_if.dyn     lkp
);
   logic [55:0]   ent [DEPTH];
   logic [DEPTH-1:0] vld;
   logic [AW:0]   cnt;
   logic [AW-1:0] h;
   logic [55:0]   cur;
   logic [55:0]   rd_ent;
   logic [9:0]    cnt_m1;

   assign h            = lkp.mac[AW-1:0] ^ AW'(lkp.filter_group_id);
   assign cur          = ent[h];
   assign lkp.dyn_hit  = vld[h] && (cur[51:0] == {lkp.filter_group_id, lkp.mac});
   assign lkp.dyn_port = cur[53:52];
   assign rd_ent       = ent[lkp.rd_idx[AW-1:0]];
   assign cnt_m1       = (cnt == '0) ? 10'h000 : 10'(cnt - 1'b1);

   // ==========================================
   // Learning and port migration
   always_ff @(posedge i_clk_sys) begin
      if (lkp.req) begin
         ent[h] <= {lkp.stamp, lkp.learn_port, lkp.filter_group_id, lkp.mac};
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         vld <= '0;
         cnt <= '0;
      end else if (lkp.req && !vld[h]) begin
         vld[h] <= 1'b1;
         cnt    <= cnt + 1'b1;
      end
   end

   // ==========================================
   // Software read port, one cycle latency
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         lkp.rd_data <= '0;
      end else if (lkp.rd_en) begin
         lkp.rd_data <= {1'b0, 4'h0, (cnt == '0), cnt_m1, rd_ent};
      end
   end
endmodule

// [core/switch_table_indirect_access.sv]
// Purpose: Indirect access to statistics counters, static and dynamic address
//          tables, plus the forwarding lookup over both address tables
// Assumes: All inputs come from logic on i_clk_sys
// Notes:   A control write is refused while an access is still in flight
//
// Summary of operation
// - Control 0x1C0E reads counter 0x0E; read upper word then lower word.
// - Bit 31 of a returned per-port counter flags overflow.
// - Bit 30 clear means not valid yet; software re-reads upper word.
// - Second port counters sit 0x20 above the first; 0x1C2E reads index 0x2E.
// - Drop counters start at index 0x100; only the lower word carries value.
// - Reading a per-port counter clears it to zero.
// - Drop counters are never cleared by a read.
// - Destination lookups search both tables; source lookups only dynamic.
// - A static match beats a dynamic match for destination lookups.
// - Static entries are never aged out.
// - Static entry bits 57:54 hold the filter group id.
// - Bit 53 set adds the filter group id to the static match key.
// - Bit 52 set forwards despite disabled port transmit or receive.
// - Static entries with bit 51 clear are ignored.
// - Bits 50:48 are a port map; 111 broadcasts except ingress port.
// - Static read 0x1001 then data words upper, 47:32, 31:16, 15:0.
// - Static write loads four data words then control 0x0007 commits.
// - Static table has eight 58-bit entries.
// - Dynamic table is readable but not writable by software.
// - Dynamic read bit 71 stays one until data is ready.
// - Bits 65:56 give entry count minus one; bit 66 marks empty.
// - Dynamic entry reports timestamp, learning port, group and address.
// - Control word at 0x04A0; bit 12 read, bits 9:0 index.
// - Lower data word at 0x04A8, bits 31:16 at 0x04AA.
`timescale 1ns/1ps
module switch_table_indirect_access #(
   parameter int DYN_DEPTH = swt_pkg::DYN_DEPTH
) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic [15:0] i_reg_addr,
   input  wire logic [15:0] i_reg_wdata,
   output logic      [15:0] o_reg_rdata,
   output logic             o_busy,
   input  wire logic        i_mib_evt,
   input  wire logic [5:0]  i_mib_idx,
   input  wire logic [15:0] i_mib_amt,
   input  wire logic [3:0]  i_drop_evt,
   input  wire logic        i_lkp_valid,
   input  wire logic        i_lkp_da,
   input  wire logic [47:0] i_lkp_mac,
   input  wire logic [3:0]  i_lkp_fid,
   input  wire logic [1:0]  i_lkp_port,
   input  wire logic [1:0]  i_age_stamp,
   output logic             o_fwd_valid,
   output logic             o_fwd_hit,
   output logic             o_fwd_static,
   output logic             o_fwd_override,
   output logic      [2:0]  o_fwd_ports,
   output logic             o_sa_hit
);
   swt_pkg::acc_state_t state;
   logic [15:0]  ctrl;
   logic [71:0]  data_q;
   logic [71:0]  view;
   logic         rd_op;
   logic [1:0]   tbl;
   logic [9:0]   idx;
   logic         ctl_wr;
   logic         mib_sel;
   logic         drop_sel;
   logic [1:0]   drop_i;
   logic         mib_clr;
   logic         st_commit;
   logic [30:0]  mib [swt_pkg::MIB_ENTRIES];
   logic [30:0]  mib_cur;
   logic [30:0]  mib_sum;
   logic [3:0][15:0] drop_cnt;
   logic [swt_pkg::ST_ENTRIES-1:0][swt_pkg::ST_W-1:0] stat_tab;
   logic [2:0]   next_ports;

   lookup_if lkp ();

   static_match #(.ENTRIES(swt_pkg::ST_ENTRIES)) u_static (
      .i_table (stat_tab),
      .lkp     (lkp.stat)
   );

   dyn_table #(.DEPTH(DYN_DEPTH), .AW($clog2(DYN_DEPTH))) u_dyn (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .lkp       (lkp.dyn)
   );

   // ==========================================
   // Control word decode
   assign rd_op  = ctrl[swt_pkg::CTL_RD_BIT];
   assign tbl    = ctrl[swt_pkg::CTL_TBL_LSB +: 2];
   assign idx    = ctrl[9:0];
   assign ctl_wr = i_reg_wr && (i_reg_addr == swt_pkg::CTRL_OFS) &&
                   (state == swt_pkg::S_IDLE);
   // Bit 5 of the index picks the port, so port 2 sits 0x20 higher
   assign mib_sel = (tbl == swt_pkg::TBL_MIB) && (idx < swt_pkg::MIB_LIMIT);
   always_comb begin
      drop_sel = tbl == swt_pkg::TBL_MIB;
      drop_i   = 2'd0;
      case (idx)
         swt_pkg::DROP_P1_TX: drop_i = 2'd0;
         swt_pkg::DROP_P2_TX: drop_i = 2'd1;
         swt_pkg::DROP_P1_RX: drop_i = 2'd2;
         swt_pkg::DROP_P2_RX: drop_i = 2'd3;
         default:             drop_sel = 1'b0;
      endcase
   end
   assign mib_clr   = (state == swt_pkg::S_LOAD) && rd_op && mib_sel;
   // Only the static table takes software writes; dynamic writes are dropped
   assign st_commit = (state == swt_pkg::S_LOAD) && !rd_op &&
                      (tbl == swt_pkg::TBL_STATIC) && (idx < 10'(swt_pkg::ST_ENTRIES));

   // ==========================================
   // Access sequencer
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state  <= swt_pkg::S_IDLE;
         ctrl   <= swt_pkg::CTRL_RST;
         o_busy <= 1'b0;
      end else begin
         case (state)
            swt_pkg::S_IDLE: begin
               if (ctl_wr) begin
                  ctrl   <= i_reg_wdata;
                  state  <= swt_pkg::S_FETCH;
                  o_busy <= 1'b1;
               end
            end
            swt_pkg::S_FETCH: begin
               state <= swt_pkg::S_LOAD;
            end
            swt_pkg::S_LOAD: begin
               state  <= swt_pkg::S_IDLE;
               o_busy <= 1'b0;
            end
            default: begin
               state  <= swt_pkg::S_IDLE;
               o_busy <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================
   // Data holding register: software writes, hardware loads read results
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         data_q <= '0;
      end else if ((state == swt_pkg::S_LOAD) && rd_op) begin
         case (tbl)
            swt_pkg::TBL_STATIC:
               data_q <= (idx < 10'(swt_pkg::ST_ENTRIES)) ?
                         {14'h0, stat_tab[idx[2:0]]} : '0;
            swt_pkg::TBL_DYN:
               data_q <= lkp.rd_data;
            swt_pkg::TBL_MIB: begin
               if (mib_sel)
                  data_q <= {40'h0, mib_cur[30], 1'b1, mib_cur[29:0]};
               else if (drop_sel)
                  data_q <= {56'h0, drop_cnt[drop_i]};
               else
                  data_q <= '0;
            end
            default: data_q <= '0;
         endcase
      end else if (i_reg_wr) begin
         case (i_reg_addr)
            swt_pkg::D71_OFS: data_q[71:64] <= i_reg_wdata[7:0];
            swt_pkg::DUP_OFS: data_q[63:48] <= i_reg_wdata;
            swt_pkg::D47_OFS: data_q[47:32] <= i_reg_wdata;
            swt_pkg::D31_OFS: data_q[31:16] <= i_reg_wdata;
            swt_pkg::D15_OFS: data_q[15:0]  <= i_reg_wdata;
            default: data_q <= data_q;
         endcase
      end
   end

   // While an access is in flight the ready flags say "not yet"
   always_comb begin
      view = data_q;
      if (o_busy && rd_op && (tbl == swt_pkg::TBL_DYN))
         view[swt_pkg::DYN_NRDY] = 1'b1;
      if (o_busy && rd_op && (tbl == swt_pkg::TBL_MIB))
         view[swt_pkg::MIB_VLD_BIT] = 1'b0;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_reg_rdata <= 16'h0000;
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            swt_pkg::CTRL_OFS: o_reg_rdata <= ctrl;
            swt_pkg::D71_OFS:  o_reg_rdata <= {8'h00, view[71:64]};
            swt_pkg::DUP_OFS:  o_reg_rdata <= view[63:48];
            swt_pkg::D47_OFS:  o_reg_rdata <= view[47:32];
            swt_pkg::D31_OFS:  o_reg_rdata <= view[31:16];
            swt_pkg::D15_OFS:  o_reg_rdata <= view[15:0];
            default:           o_reg_rdata <= 16'h0000;
         endcase
      end
   end

   // ==========================================
   // Static table; only reset and a software commit ever touch it
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         for (int i = 0; i < swt_pkg::ST_ENTRIES; i++)
            stat_tab[i] <= swt_pkg::ST_RST;
      end else if (st_commit) begin
         stat_tab[idx[2:0]] <= data_q[swt_pkg::ST_W-1:0];
      end
   end

   // ==========================================
   // Per-port counters: read clears, an event in the clear cycle survives
   assign mib_cur = mib[idx[5:0]];
   assign mib_sum = {1'b0, mib[i_mib_idx][29:0]} + {15'h0, i_mib_amt};

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         for (int i = 0; i < swt_pkg::MIB_ENTRIES; i++)
            mib[i] <= '0;
      end else begin
         if (mib_clr)
            mib[idx[5:0]] <= '0;
         if (i_mib_evt) begin
            if (mib_clr && (idx[5:0] == i_mib_idx))
               mib[i_mib_idx] <= {15'h0, i_mib_amt};
            else
               mib[i_mib_idx] <= {mib[i_mib_idx][30] | mib_sum[30], mib_sum[29:0]};
         end
      end
   end

   // Drop counters wrap silently; software tracks overflow itself
   genvar g;
   generate
      for (g = 0; g < swt_pkg::DROP_NUM; g++) begin : g_drop
         always_ff @(posedge i_clk_sys) begin
            if (i_rst)
               drop_cnt[g] <= swt_pkg::DROP_RST;
            else if (i_drop_evt[g])
               drop_cnt[g] <= drop_cnt[g] + 16'h0001;
         end
      end
   endgenerate

   // ==========================================
   // Forwarding lookup
   assign lkp.mac        = i_lkp_mac;
   assign lkp.filter_group_id        = i_lkp_fid;
   assign lkp.req        = i_lkp_valid && !i_lkp_da;
   assign lkp.learn_port = i_lkp_port;
   assign lkp.stamp      = i_age_stamp;
   assign lkp.rd_en      = (state == swt_pkg::S_FETCH) && rd_op && (tbl == swt_pkg::TBL_DYN);
   assign lkp.rd_idx     = idx;

   function automatic logic [2:0] one_hot(input logic [1:0] p);
      case (p)
         2'd0:    one_hot = 3'h1;
         2'd1:    one_hot = 3'h2;
         2'd2:    one_hot = 3'h4;
         default: one_hot = 3'h0;
      endcase
   endfunction

   always_comb begin
      next_ports = 3'h0;
      if (lkp.st_hit) begin
         next_ports = lkp.st_ports;
         if (lkp.st_ports == swt_pkg::PORTS_BCAST)
            next_ports = lkp.st_ports & ~one_hot(i_lkp_port);
      end else if (lkp.dyn_hit) begin
         next_ports = one_hot(lkp.dyn_port);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_fwd_valid    <= 1'b0;
         o_fwd_hit      <= 1'b0;
         o_fwd_static   <= 1'b0;
         o_fwd_override <= 1'b0;
         o_fwd_ports    <= 3'h0;
         o_sa_hit       <= 1'b0;
      end else begin
         o_fwd_valid    <= i_lkp_valid && i_lkp_da;
         o_fwd_hit      <= i_lkp_valid && i_lkp_da && (lkp.st_hit || lkp.dyn_hit);
         o_fwd_static   <= i_lkp_valid && i_lkp_da && lkp.st_hit;
         o_fwd_override <= i_lkp_valid && i_lkp_da && lkp.st_hit && lkp.st_ovr;
         o_fwd_ports    <= (i_lkp_valid && i_lkp_da) ? next_ports : 3'h0;
         o_sa_hit       <= i_lkp_valid && !i_lkp_da && lkp.dyn_hit;
      end
   end

   // ==========================================
   // Checks
   property p_static_wins;
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_lkp_valid && i_lkp_da && lkp.st_hit) |=> (o_fwd_static && o_fwd_hit);
   endproperty
   a_static_wins: assert property (p_static_wins) else $error("static match lost");

   property p_sa_dyn_only;
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_lkp_valid && !i_lkp_da) |=> (!o_fwd_static && !o_fwd_valid &&
                                      (o_sa_hit == $past(lkp.dyn_hit)));
   endproperty
   a_sa_dyn_only: assert property (p_sa_dyn_only) else $error("source lookup used static");

   property p_read_clear;
      @(posedge i_clk_sys) disable iff (i_rst)
      (mib_clr && !i_mib_evt) |=> (mib[$past(idx[5:0])] == 31'h0);
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("counter kept after read");

   property p_drop_kept;
      @(posedge i_clk_sys) disable iff (i_rst)
      ((state == swt_pkg::S_LOAD) && rd_op && drop_sel && (i_drop_evt == 4'h0))
         |=> $stable(drop_cnt);
   endproperty
   a_drop_kept: assert property (p_drop_kept) else $error("drop counter changed on read");

   property p_not_valid;
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_reg_rd && (i_reg_addr == swt_pkg::D31_OFS) && o_busy && rd_op &&
       (tbl == swt_pkg::TBL_MIB)) |=> (o_reg_rdata[14] == 1'b0);
   endproperty
   a_not_valid: assert property (p_not_valid) else $error("valid flag shown too early");

   property p_not_ready;
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_reg_rd && (i_reg_addr == swt_pkg::D71_OFS) && o_busy && rd_op &&
       (tbl == swt_pkg::TBL_DYN)) |=> o_reg_rdata[7];
   endproperty
   a_not_ready: assert property (p_not_ready) else $error("ready flag shown too early");

   property p_commit;
      @(posedge i_clk_sys) disable iff (i_rst)
      st_commit |=> (stat_tab[$past(idx[2:0])] == $past(data_q[57:0]));
   endproperty
   a_commit: assert property (p_commit) else $error("static entry not committed");

   property p_access_len;
      @(posedge i_clk_sys) disable iff (i_rst)
      ctl_wr |=> o_busy ##1 o_busy ##1 !o_busy;
   endproperty
   a_access_len: assert property (p_access_len) else $error("access length wrong");
endmodule

// [testbench/switch_table_indirect_access_tb.sv]
// Purpose: Self-checking bench for the table indirect access block
// Assumes: Inputs driven on the falling edge, outputs sampled there too
// Notes:   Dynamic depth shrunk to 16 so the learned table stays small
`timescale 1ns/1ps
module switch_table_indirect_access_tb;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        reg_wr = 1'b0, reg_rd = 1'b0, mib_evt = 1'b0, lkp_valid = 1'b0, lkp_da = 1'b0;
   logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, mib_amt = 16'h0000, rdata;
   logic [5:0]  mib_idx = 6'h00;
   logic [3:0]  drop_evt = 4'h0;
   logic [47:0] lkp_mac = 48'h0;
   logic [1:0]  lkp_port = 2'h0;
   logic [3:0]  lkp_fid = 4'h0;
   logic        busy, fv, fhit, fst, fovr, sa_hit;
   logic [2:0]  fports;
   int          err_count = 0;
   int          tests_run = 0;
   always #2.5 clk_sys = ~clk_sys;
   switch_table_indirect_access #(.DYN_DEPTH(16)) u_switch_table_indirect_access (
      .i_clk_sys(clk_sys), .i_rst(rst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
      .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata), .o_busy(busy),
      .i_mib_evt(mib_evt), .i_mib_idx(mib_idx), .i_mib_amt(mib_amt), .i_drop_evt(drop_evt),
      .i_lkp_valid(lkp_valid), .i_lkp_da(lkp_da), .i_lkp_mac(lkp_mac), .i_lkp_fid(lkp_fid),
      .i_lkp_port(lkp_port), .i_age_stamp(2'h2), .o_fwd_valid(fv), .o_fwd_hit(fhit),
      .o_fwd_static(fst), .o_fwd_override(fovr), .o_fwd_ports(fports), .o_sa_hit(sa_hit));
   // ==========================================
   // Access tasks
   task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge clk_sys);
      reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      @(negedge clk_sys);
      reg_rd = 1'b1; reg_addr = a;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      chk("rdata", rdata, exp);
   endtask
   // Control write, then wait for the access to finish under a bound
   task automatic ctl(input logic [15:0] d);
      wr(swt_pkg::CTRL_OFS, d);
      for (int n = 0; n < 20 && busy !== 1'b0; n++) @(negedge clk_sys);
      chk("busy", {15'h0000, busy}, 16'h0000);
   endtask
   task automatic ev(input logic [5:0] idx, input logic [15:0] amt);
      @(negedge clk_sys);
      mib_evt = 1'b1; mib_idx = idx; mib_amt = amt;
      @(negedge clk_sys);
      mib_evt = 1'b0;
   endtask
   task automatic drop1();
      @(negedge clk_sys);
      drop_evt = 4'h1;
      @(negedge clk_sys);
      drop_evt = 4'h0;
   endtask
   // Expected lookup byte is {sa_hit, fwd_valid, hit, static, override, ports}
   task automatic lk(input logic da, input logic [47:0] mac, input logic [1:0] p,
                     input logic [7:0] exp);
      @(negedge clk_sys);
      lkp_valid = 1'b1; lkp_da = da; lkp_mac = mac; lkp_port = p;
      @(negedge clk_sys);
      lkp_valid = 1'b0;
      chk("lookup", {8'h00, sa_hit, fv, fhit, fst, fovr, fports}, {8'h00, exp});
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ==========================================
   // Watchdog: tests need well under 1000 cycles
   initial begin
      #(5 * 5000);
      err_count++;
      summarize();
   end
   // ==========================================
   // Main sequence
   initial begin
      repeat (12) @(negedge clk_sys);
      rst = 1'b0;
      ctl(16'h1800);
      rd(16'h04a2, 16'h0004);
      wr(swt_pkg::DUP_OFS, 16'h001f);
      wr(swt_pkg::D47_OFS, 16'h0a0b);
      wr(swt_pkg::D31_OFS, 16'h0c0d);
      wr(swt_pkg::D15_OFS, 16'h0e0f);
      ctl(16'h0007);
      wr(swt_pkg::DUP_OFS, 16'h0001);
      wr(swt_pkg::D47_OFS, 16'h0000);
      wr(swt_pkg::D31_OFS, 16'h0000);
      wr(swt_pkg::D15_OFS, 16'h1111);
      ctl(16'h0001);
      ctl(16'h1007);
      rd(swt_pkg::DUP_OFS, 16'h001f);
      rd(swt_pkg::D47_OFS, 16'h0a0b);
      rd(swt_pkg::D31_OFS, 16'h0c0d);
      rd(swt_pkg::D15_OFS, 16'h0e0f);
      ctl(16'h1001);
      rd(swt_pkg::DUP_OFS, 16'h0001);
      rd(swt_pkg::D15_OFS, 16'h1111);
      lk(1'b1, 48'h0000_0000_1111, 2'h0, 8'h40);
      lk(1'b1, 48'h0a0b_0c0d_0e0f, 2'h0, 8'h7e);
      lk(1'b1, 48'h0a0b_0c0d_0e0f, 2'h1, 8'h7d);
      lk(1'b0, 48'h0a0b_0c0d_0e0f, 2'h1, 8'h00);
      lk(1'b0, 48'h0a0b_0c0d_0e0f, 2'h1, 8'h80);
      lk(1'b1, 48'h0a0b_0c0d_0e0f, 2'h0, 8'h7e);
      lk(1'b0, 48'h0000_0000_3333, 2'h0, 8'h00);
      lk(1'b1, 48'h0000_0000_3333, 2'h1, 8'h61);
      wr(swt_pkg::DUP_OFS, 16'h00ea);
      wr(swt_pkg::D47_OFS, 16'h0000);
      wr(swt_pkg::D31_OFS, 16'h0000);
      wr(swt_pkg::D15_OFS, 16'h5555);
      ctl(16'h0002);
      lk(1'b1, 48'h0000_0000_5555, 2'h0, 8'h40);
      lkp_fid = 4'h3;
      lk(1'b1, 48'h0000_0000_5555, 2'h0, 8'h72);
      // Read while the access is still in flight shows the not-ready flag
      wr(swt_pkg::CTRL_OFS, 16'h1803);
      rd(swt_pkg::D71_OFS, 16'h0080);
      rd(swt_pkg::D71_OFS, 16'h0000);
      rd(swt_pkg::DUP_OFS, 16'h0180);
      rd(swt_pkg::D15_OFS, 16'h3333);
      ev(6'h0e, 16'h0005);
      ev(6'h0e, 16'h0005);
      ev(6'h2e, 16'h0003);
      ctl(16'h1c0e);
      rd(swt_pkg::D31_OFS, 16'h4000);
      rd(swt_pkg::D15_OFS, 16'h000a);
      ctl(16'h1c0e);
      rd(swt_pkg::D15_OFS, 16'h0000);
      wr(swt_pkg::CTRL_OFS, 16'h1c2e);
      rd(swt_pkg::D31_OFS, 16'h0000);
      rd(swt_pkg::D15_OFS, 16'h0003);
      drop1();
      drop1();
      ctl(16'h1d00);
      rd(swt_pkg::D15_OFS, 16'h0002);
      ctl(16'h1d00);
      rd(swt_pkg::D15_OFS, 16'h0002);
      summarize();
   end
endmodule
